// >>> common/auxreg_ctrl_if.sv
// Interface between the register file and the regulator sequencer.
// Assumes both ends share pclk.
`timescale 1ns/1ps
interface auxreg_ctrl_if;
	logic [1:0] voltage_select;
	logic enable_request;
	logic locked;
	logic regulator_on;
	logic [1:0] applied_voltage;
	modport regs (output voltage_select, output enable_request, input locked,
		input regulator_on, input applied_voltage);
	modport seq (input voltage_select, input enable_request, output locked,
		output regulator_on, output applied_voltage);
endinterface

// >>> common/auxreg_pkg.sv
// Package for the auxiliary regulator control block: register map, field layout,
// reset values, mode and voltage encodings.
// Assumes a 32-bit APB slave with word-aligned registers.
package auxreg_pkg;
	// Register byte offsets
	localparam logic [11:0] AUXREG_CTRL_OFFSET = 12'h000; // hardware_control_one
	localparam logic [11:0] AUXREG_ENABLE_OFFSET = 12'h004; // enable register
	localparam logic [11:0] AUXREG_STAT0_OFFSET = 12'h008; // first supply status
	localparam logic [11:0] AUXREG_STAT1_OFFSET = 12'h00c; // second supply status
	// Field positions
	localparam int AUXREG_VSEL_LSB = 0;
	localparam int AUXREG_LOCK_BIT = 4;
	localparam int AUXREG_EN_BIT = 0;
	localparam int AUXREG_UV_BIT = 0;
	localparam int AUXREG_OC_BIT = 0;
	localparam int AUXREG_ACTIVE_BIT = 1;
	localparam int AUXREG_MODE_LSB = 8;
	// Voltage selector encodings
	localparam logic [1:0] AUXREG_V5P0 = 2'h0;
	localparam logic [1:0] AUXREG_V3P3 = 2'h1;
	localparam logic [1:0] AUXREG_V1P8 = 2'h2;
	localparam logic [1:0] AUXREG_V1P2 = 2'h3;
	localparam logic [1:0] AUXREG_VSEL_RESET = AUXREG_V3P3;
	// System modes, one-hot codes
	typedef enum logic [5:0] {
		AUXREG_MODE_INIT = 6'h01,
		AUXREG_MODE_NORMAL = 6'h02,
		AUXREG_MODE_STOP = 6'h04,
		AUXREG_MODE_SLEEP = 6'h08,
		AUXREG_MODE_RESTART = 6'h10,
		AUXREG_MODE_FAILSAFE = 6'h20
	} auxreg_mode_type;
	localparam logic [2:0] AUXREG_SYNC_RESET = 3'h0;
endpackage

// >>> hw/auxreg_seq.sv
// Regulator sequencer: mode handling, write-once voltage lock, applied settings.
// Assumes the system mode is a registered one-hot code on pclk.
`timescale 1ns/1ps
module auxreg_seq
	import auxreg_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input auxreg_mode_type system_mode,
	auxreg_ctrl_if.seq ctrl
);
	logic locked;
	logic regulator_on;
	logic [1:0] applied_voltage;
	logic next_locked;
	logic next_regulator_on;
	logic [1:0] next_applied_voltage;

	////////////////////////////////////////////////////////////////////////
	// Mode table: off, follow software, or hold
	always_comb
	begin
		next_locked = locked;
		next_regulator_on = regulator_on;
		next_applied_voltage = applied_voltage;
		case (system_mode)
			AUXREG_MODE_INIT, AUXREG_MODE_FAILSAFE:
			begin
				next_regulator_on = 1'b0;
			end
			AUXREG_MODE_NORMAL:
			begin
				next_regulator_on = ctrl.enable_request;
				if (!locked)
				begin
					next_applied_voltage = ctrl.voltage_select;
				end
				if (ctrl.enable_request)
				begin
					next_locked = 1'b1;
				end
			end
			default:
			begin
				next_regulator_on = regulator_on; // Stop, sleep, restart hold
			end
		endcase
	end

	// Lock is cleared only by power-up reset
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			locked <= 1'b0;
			regulator_on <= 1'b0;
			applied_voltage <= AUXREG_VSEL_RESET;
		end
		else
		begin
			locked <= next_locked;
			regulator_on <= next_regulator_on;
			applied_voltage <= next_applied_voltage;
		end
	end

	assign ctrl.locked = locked;
	assign ctrl.regulator_on = regulator_on;
	assign ctrl.applied_voltage = applied_voltage;

	a_lock_sticks: assert property (@(posedge pclk) disable iff (!presetn)
		locked |=> locked) else $error("lock released");
	a_off_in_init: assert property (@(posedge pclk) disable iff (!presetn)
		(system_mode == AUXREG_MODE_INIT || system_mode == AUXREG_MODE_FAILSAFE)
		|=> !regulator_on) else $error("regulator on in init or fail-safe");
	a_voltage_frozen: assert property (@(posedge pclk) disable iff (!presetn)
		locked |=> $stable(applied_voltage)) else $error("voltage changed after lock");
	a_hold_mode: assert property (@(posedge pclk) disable iff (!presetn)
		(system_mode == AUXREG_MODE_STOP || system_mode == AUXREG_MODE_SLEEP ||
		system_mode == AUXREG_MODE_RESTART) |=> $stable(regulator_on) && $stable(applied_voltage))
		else $error("settings moved in hold mode");
	a_enable_follows: assert property (@(posedge pclk) disable iff (!presetn)
		system_mode == AUXREG_MODE_NORMAL |=> regulator_on == $past(ctrl.enable_request))
		else $error("regulator does not follow enable");
	a_enable_locks: assert property (@(posedge pclk) disable iff (!presetn)
		(system_mode == AUXREG_MODE_NORMAL && ctrl.enable_request) |=> locked)
		else $error("enable did not lock");
endmodule // auxreg_seq

// >>> hw/auxreg_sync.sv
// Three-stage synchroniser for pin-level inputs.
// Assumes the input is asynchronous to pclk; output changes when stages two and three agree.
`timescale 1ns/1ps
module auxreg_sync
	import auxreg_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic async_in,
	output logic sync_out
);
	logic [2:0] stage;
	logic [2:0] next_stage;
	logic next_sync_out;

	////////////////////////////////////////////////////////////////////////
	// Shift chain; first stage only feeds the second
	always_comb
	begin
		next_stage = {stage[1:0], async_in};
		next_sync_out = (stage[1] == stage[2]) ? stage[2] : sync_out;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			stage <= AUXREG_SYNC_RESET;
			sync_out <= 1'b0;
		end
		else
		begin
			stage <= next_stage;
			sync_out <= next_sync_out;
		end
	end
endmodule // auxreg_sync

// >>> hw/auxreg_top.sv
// Auxiliary regulator control: APB register file, status flags, sequencer instance.
// Assumes system mode arrives registered on pclk; sense pins are asynchronous comparators.
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/1ps

module auxreg_top
	import auxreg_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input auxreg_mode_type system_mode,
	input wire logic shunt_sense_pin,
	input wire logic output_undervoltage_pin,
	output logic transistor_base_drive_pin,
	output logic [1:0] aux_voltage_level,
	output logic current_limit_active
);
	auxreg_ctrl_if ctrl ();
	logic [1:0] aux_voltage_select;
	logic aux_regulator_enable;
	logic aux_overcurrent_flag;
	logic aux_undervoltage_flag;
	logic oc_sync;
	logic uv_sync;
	logic [1:0] next_aux_voltage_select;
	logic next_aux_regulator_enable;
	logic next_aux_overcurrent_flag;
	logic next_aux_undervoltage_flag;
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	logic next_base_drive;
	logic [1:0] next_voltage_level;
	logic next_limit;
	logic setup;
	logic wr_ctrl;
	logic wr_en;
	logic wr_stat0;
	logic wr_stat1;

	// Decode a mapped byte address
	function automatic logic addr_mapped(input logic [11:0] a);
		addr_mapped = (a == AUXREG_CTRL_OFFSET) || (a == AUXREG_ENABLE_OFFSET) ||
			(a == AUXREG_STAT0_OFFSET) || (a == AUXREG_STAT1_OFFSET);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	auxreg_sync u_oc_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(shunt_sense_pin),
		.sync_out(oc_sync)
	);

	auxreg_sync u_uv_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(output_undervoltage_pin),
		.sync_out(uv_sync)
	);

	auxreg_seq u_seq (
		.pclk(pclk),
		.presetn(presetn),
		.system_mode(system_mode),
		.ctrl(ctrl)
	);

	assign ctrl.voltage_select = aux_voltage_select;
	assign ctrl.enable_request = aux_regulator_enable;

	////////////////////////////////////////////////////////////////////////
	// APB strobes; writes land on the access-phase edge, one wait-free cycle
	assign setup = psel && !penable;
	assign wr_ctrl = psel && penable && pready && pwrite && pstrb[0] &&
		paddr == AUXREG_CTRL_OFFSET;
	assign wr_en = psel && penable && pready && pwrite && pstrb[0] &&
		paddr == AUXREG_ENABLE_OFFSET;
	assign wr_stat0 = psel && penable && pready && pwrite && pstrb[0] &&
		paddr == AUXREG_STAT0_OFFSET;
	assign wr_stat1 = psel && penable && pready && pwrite && pstrb[0] &&
		paddr == AUXREG_STAT1_OFFSET;

	// Register file and flags; hardware set wins over software clear
	always_comb
	begin
		next_aux_voltage_select = aux_voltage_select;
		next_aux_regulator_enable = aux_regulator_enable;
		if (wr_ctrl && !ctrl.locked)
		begin
			next_aux_voltage_select = pwdata[AUXREG_VSEL_LSB +: 2];
		end
		if (wr_en)
		begin
			next_aux_regulator_enable = pwdata[AUXREG_EN_BIT];
		end
		next_aux_overcurrent_flag = aux_overcurrent_flag;
		if (wr_stat1 && pwdata[AUXREG_OC_BIT])
		begin
			next_aux_overcurrent_flag = 1'b0; // Write one to clear
		end
		if (oc_sync)
		begin
			next_aux_overcurrent_flag = 1'b1; // Clear has no effect while present
		end
		next_aux_undervoltage_flag = aux_undervoltage_flag;
		if (wr_stat0 && pwdata[AUXREG_UV_BIT])
		begin
			next_aux_undervoltage_flag = 1'b0;
		end
		if (uv_sync && ctrl.regulator_on)
		begin
			next_aux_undervoltage_flag = 1'b1;
		end
	end

	// Read path and answer; ready rises one cycle after setup
	always_comb
	begin
		next_prdata = 32'h0000_0000;
		next_pready = setup;
		next_pslverr = setup && !addr_mapped(paddr);
		if (setup && !pwrite)
		begin
			case (paddr)
				AUXREG_CTRL_OFFSET:
				begin
					next_prdata[AUXREG_VSEL_LSB +: 2] = ctrl.locked ? ctrl.applied_voltage :
						aux_voltage_select;
					next_prdata[AUXREG_LOCK_BIT] = ctrl.locked;
				end
				AUXREG_ENABLE_OFFSET:
				begin
					next_prdata[AUXREG_EN_BIT] = aux_regulator_enable;
				end
				AUXREG_STAT0_OFFSET:
				begin
					next_prdata[AUXREG_UV_BIT] = aux_undervoltage_flag;
				end
				AUXREG_STAT1_OFFSET:
				begin
					next_prdata[AUXREG_OC_BIT] = aux_overcurrent_flag;
					next_prdata[AUXREG_ACTIVE_BIT] = ctrl.regulator_on;
					next_prdata[AUXREG_MODE_LSB +: 6] = system_mode;
				end
				default:
				begin
					next_prdata = 32'h0000_0000;
				end
			endcase
		end
	end

	// Regulator drive outputs; overcurrent only limits, never switches off
	always_comb
	begin
		next_base_drive = ctrl.regulator_on;
		next_voltage_level = ctrl.applied_voltage;
		next_limit = ctrl.regulator_on && oc_sync;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			aux_voltage_select <= AUXREG_VSEL_RESET;
			aux_regulator_enable <= 1'b0;
			aux_overcurrent_flag <= 1'b0;
			aux_undervoltage_flag <= 1'b0;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			transistor_base_drive_pin <= 1'b0;
			aux_voltage_level <= AUXREG_VSEL_RESET;
			current_limit_active <= 1'b0;
		end
		else
		begin
			aux_voltage_select <= next_aux_voltage_select;
			aux_regulator_enable <= next_aux_regulator_enable;
			aux_overcurrent_flag <= next_aux_overcurrent_flag;
			aux_undervoltage_flag <= next_aux_undervoltage_flag;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
			transistor_base_drive_pin <= next_base_drive;
			aux_voltage_level <= next_voltage_level;
			current_limit_active <= next_limit;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks: overcurrent flag and current limit
	// Comparator seen means flag set on the next edge
	a_oc_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
		oc_sync
		|=> aux_overcurrent_flag)
		else $error("overcurrent flag not set");
	// Clear refused while the condition stands
	a_oc_clear_held: assert property (@(posedge pclk) disable iff (!presetn)
		(aux_overcurrent_flag && oc_sync)
		|=> aux_overcurrent_flag)
		else $error("flag cleared while present");
	// Clear honoured once the condition is gone
	a_oc_clear_works: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_stat1 && pwdata[AUXREG_OC_BIT] && !oc_sync)
		|=> !aux_overcurrent_flag)
		else $error("overcurrent flag clear ignored");
	// Overcurrent never switches the regulator off
	a_oc_no_shutdown: assert property (@(posedge pclk) disable iff (!presetn)
		(oc_sync && ctrl.regulator_on && system_mode == AUXREG_MODE_NORMAL &&
		aux_regulator_enable && !wr_en) |=> ctrl.regulator_on)
		else $error("overcurrent switched regulator off");
	// Limit applied while running into the shunt threshold
	a_limit_on_oc: assert property (@(posedge pclk) disable iff (!presetn)
		(ctrl.regulator_on && oc_sync)
		|=> current_limit_active)
		else $error("current limit not applied");
	// No limit without an overcurrent, so normal load is never throttled
	a_limit_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		!(ctrl.regulator_on && oc_sync)
		|=> !current_limit_active)
		else $error("current limit without overcurrent");

	// Checks: undervoltage flag
	// Sag under drive is always reported
	a_uv_when_on: assert property (@(posedge pclk) disable iff (!presetn)
		(uv_sync && ctrl.regulator_on)
		|=> aux_undervoltage_flag)
		else $error("undervoltage not flagged");
	// A switched-off regulator raises no undervoltage
	a_uv_off_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		(!ctrl.regulator_on && !aux_undervoltage_flag)
		|=> !aux_undervoltage_flag)
		else $error("undervoltage flagged while off");

	// Checks: regulator control
	// Drive can only start from a normal-mode decision
	a_drive_in_normal: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(transistor_base_drive_pin)
		|-> $past(system_mode, 2) == AUXREG_MODE_NORMAL)
		else $error("regulator started outside normal mode");
	// Applied voltage only moves in normal mode
	a_level_in_normal: assert property (@(posedge pclk) disable iff (!presetn)
		$changed(aux_voltage_level)
		|-> $past(system_mode, 2) == AUXREG_MODE_NORMAL)
		else $error("voltage level moved outside normal mode");
	// Enable stays writable, before and after the lock
	a_en_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en
		|=> aux_regulator_enable == $past(pwdata[AUXREG_EN_BIT]))
		else $error("enable write lost");
	// Voltage select takes any code while unlocked
	a_vsel_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_ctrl && !ctrl.locked)
		|=> aux_voltage_select == $past(pwdata[AUXREG_VSEL_LSB +: 2]))
		else $error("voltage write lost while unlocked");
	// Voltage select frozen once locked
	a_vsel_ignored: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl.locked
		|=> $stable(aux_voltage_select))
		else $error("voltage field written after lock");

	// Checks: register reads and bus answer
	// Locked control read shows the applied code
	a_rd_locked_vsel: assert property (@(posedge pclk) disable iff (!presetn)
		(setup && !pwrite && paddr == AUXREG_CTRL_OFFSET && ctrl.locked)
		|=> prdata[AUXREG_VSEL_LSB +: 2] == $past(ctrl.applied_voltage))
		else $error("locked voltage read wrong");
	// Second status word mirrors flag and regulator state
	a_rd_stat1_flags: assert property (@(posedge pclk) disable iff (!presetn)
		(setup && !pwrite && paddr == AUXREG_STAT1_OFFSET)
		|=> prdata[AUXREG_OC_BIT] == $past(aux_overcurrent_flag) &&
		prdata[AUXREG_ACTIVE_BIT] == $past(ctrl.regulator_on))
		else $error("status read disagrees with flags");
	// One wait-free answer per setup
	a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
		setup
		|=> pready ##1 !pready)
		else $error("apb answer timing wrong");
	// Unmapped address answered with an error
	a_slverr_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
		(setup && !addr_mapped(paddr))
		|=> pready && pslverr)
		else $error("unmapped access not refused");
	// Mapped address never flagged
	a_slverr_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		(setup && addr_mapped(paddr))
		|=> !pslverr)
		else $error("mapped access refused");
	// No answer without a setup cycle
	a_ready_needs_setup: assert property (@(posedge pclk) disable iff (!presetn)
		!setup
		|=> !pready)
		else $error("ready without setup");
endmodule // auxreg_top

// >>> tb/auxreg_load_model.sv
// Behavioural model of the external pass transistor, shunt and output node.
// Assumes the bench commands overload and sag; both pins are plain levels.
`timescale 1ns/1ps
module auxreg_load_model
(
	input wire logic base_drive,
	input wire logic overload_cmd,
	input wire logic sag_cmd,
	output logic shunt_sense_pin,
	output logic output_undervoltage_pin
);
	// Shunt only carries current while the transistor conducts
	assign shunt_sense_pin = base_drive & overload_cmd;
	// Sag only shows under drive, so a stale fault never races the enable
	assign output_undervoltage_pin = base_drive & sag_cmd;
endmodule // auxreg_load_model

// >>> tb/tb.sv
// Self-checking bench for the auxiliary regulator control block.
// Assumes an APB slave that answers by itself; every wait is bounded.
`timescale 1ns/1ps
module tb
	import auxreg_pkg::*;
;
	logic pclk;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hf;
	logic overload = 1'b0;
	logic sag = 1'b0;
	auxreg_mode_type system_mode = AUXREG_MODE_INIT;
	logic [31:0] prdata, rd;
	logic pready, pslverr, drive, limit, shunt, uv, err, on_exp, en;
	logic [1:0] level, vsel;
	logic [15:0] lfsr_state;
	int mismatches, tests_run;
	auxreg_mode_type modes [6] = '{AUXREG_MODE_STOP, AUXREG_MODE_SLEEP, AUXREG_MODE_RESTART,
		AUXREG_MODE_NORMAL, AUXREG_MODE_FAILSAFE, AUXREG_MODE_NORMAL};

	auxreg_top auxreg_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .system_mode(system_mode),
		.shunt_sense_pin(shunt), .output_undervoltage_pin(uv),
		.transistor_base_drive_pin(drive), .aux_voltage_level(level),
		.current_limit_active(limit));
	auxreg_load_model auxreg_load_model_i (.base_drive(drive), .overload_cmd(overload),
		.sag_cmd(sag), .shunt_sense_pin(shunt), .output_undervoltage_pin(uv));

	////////////////////////////////////////////////////////////////////////////////
	// Clock, 20 ns period
	initial
	begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	// Random source, fixed start so runs repeat
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// Regulator state expected after a mode step
	function automatic logic exp_on(auxreg_mode_type m, logic e, logic prev);
		if (m == AUXREG_MODE_NORMAL)
			return e;
		if (m == AUXREG_MODE_INIT || m == AUXREG_MODE_FAILSAFE)
			return 1'b0;
		return prev;
	endfunction

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// Reset held four cycles; also used mid-run as a fresh power-up
	task automatic power_up();
		presetn <= 1'b0;
		idle(4);
		presetn <= 1'b1;
		idle(1);
	endtask

	// One APB transfer; request held until pready is seen at an edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 16 && pready !== 1'b1; i++)
			@(posedge pclk);
		if (i == 16)
		begin
			mismatches++;
			end_of_test();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic set_mode(input auxreg_mode_type m);
		@(posedge pclk);
		system_mode <= m;
		idle(3);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		lfsr_state = 16'h0002;
		repeat (12) lfsr_state = lfsr_next(lfsr_state); // Stir past the sparse start
		power_up();
		check("level", {30'h0, level}, {30'h0, AUXREG_VSEL_RESET});
		apb(1'b0, AUXREG_CTRL_OFFSET, 32'h0);
		check("ctrl", rd, 32'h1);
		// Enable in Init must not start the regulator
		apb(1'b1, AUXREG_ENABLE_OFFSET, 32'h1);
		idle(3);
		check("init drive", {31'h0, drive}, 32'h0);
		apb(1'b1, AUXREG_ENABLE_OFFSET, 32'h0);
		set_mode(AUXREG_MODE_NORMAL);
		// Every code applies while unlocked; configuration before enable
		for (int v = 0; v < 4; v++)
		begin
			apb(1'b1, AUXREG_CTRL_OFFSET, {30'h0, v[1:0]});
			idle(3);
			check("level", {30'h0, level}, v);
			check("drive", {31'h0, drive}, 32'h0);
		end
		lfsr_state = lfsr_next(lfsr_state);
		vsel = lfsr_state[3:2];
		apb(1'b1, AUXREG_CTRL_OFFSET, {30'h0, vsel});
		apb(1'b1, AUXREG_ENABLE_OFFSET, 32'h1);
		idle(3);
		check("drive", {31'h0, drive}, 32'h1);
		// Later voltage writes bounce off the lock
		apb(1'b1, AUXREG_CTRL_OFFSET, {30'h0, ~vsel});
		apb(1'b0, AUXREG_CTRL_OFFSET, 32'h0);
		check("ctrl", rd, {27'h0, 1'b1, 2'h0, vsel});
		check("level", {30'h0, level}, {30'h0, vsel});
		// Enable toggles freely, voltage frozen
		for (int k = 0; k < 4; k++)
		begin
			apb(1'b1, AUXREG_ENABLE_OFFSET, {31'h0, k[0]});
			idle(3);
			check("toggle", {29'h0, drive, level}, {29'h0, k[0], vsel});
		end
		// Mode table with random enable requests
		on_exp = 1'b1;
		for (int k = 0; k < 6; k++)
		begin
			set_mode(modes[k]);
			lfsr_state = lfsr_next(lfsr_state);
			en = lfsr_state[4];
			apb(1'b1, AUXREG_ENABLE_OFFSET, {31'h0, en});
			idle(3);
			on_exp = exp_on(modes[k], en, on_exp);
			check("mode drive", {31'h0, drive}, {31'h0, on_exp});
			apb(1'b0, AUXREG_STAT1_OFFSET, 32'h0);
			check("stat1", rd, {18'h0, modes[k], 6'h0, on_exp, 1'b0});
		end
		apb(1'b1, AUXREG_ENABLE_OFFSET, 32'h1);
		idle(2);
		// Byte lane zero off: enable write must be ignored
		pstrb <= 4'h0;
		apb(1'b1, AUXREG_ENABLE_OFFSET, 32'h0);
		pstrb <= 4'hf;
		idle(3);
		check("strobe", {31'h0, drive}, 32'h1);
		// Overcurrent: limit and flag only, clear refused while present
		overload <= 1'b1;
		idle(8);
		check("limit", {30'h0, limit, drive}, 32'h3);
		apb(1'b1, AUXREG_STAT1_OFFSET, 32'h1);
		apb(1'b0, AUXREG_STAT1_OFFSET, 32'h0);
		check("oc held", rd, {18'h0, AUXREG_MODE_NORMAL, 8'h3});
		overload <= 1'b0;
		idle(8);
		apb(1'b1, AUXREG_STAT1_OFFSET, 32'h1);
		apb(1'b0, AUXREG_STAT1_OFFSET, 32'h0);
		check("oc clear", rd, {18'h0, AUXREG_MODE_NORMAL, 8'h2});
		// Undervoltage while enabled, then cleared
		sag <= 1'b1;
		idle(8);
		sag <= 1'b0;
		apb(1'b0, AUXREG_STAT0_OFFSET, 32'h0);
		check("uv", rd, 32'h1);
		apb(1'b1, AUXREG_STAT0_OFFSET, 32'h1);
		apb(1'b0, AUXREG_STAT0_OFFSET, 32'h0);
		check("uv clear", rd, 32'h0);
		// Unmapped address refused
		apb(1'b0, 12'h010, 32'h0);
		check("unmapped", {rd[30:0], err}, 32'h1);
		// Fresh power-up releases the lock
		power_up();
		apb(1'b0, AUXREG_CTRL_OFFSET, 32'h0);
		check("relock", {rd[29:0], level}, {30'h1, AUXREG_VSEL_RESET});
		apb(1'b1, AUXREG_CTRL_OFFSET, {30'h0, vsel});
		idle(3);
		check("unlocked", {30'h0, level}, {30'h0, vsel});
		end_of_test();
	end
endmodule // tb
